/* rtl/eee_lpi_wake.sv */
`timescale 1ns/1ps
// low power idle sequencing, eee gating and wake event detection for one port
// Summary of operation
// - lpi request on tx mii starts sleep signal
// - transmitter goes quiet after sleep signal
// - quiet and refresh alternate until lpi ends
// - wake signal for fixed time, then normal
// - no frame is cut by lpi transitions
// - refresh about 200us every 20ms
// - sleep signal lasts at least 200us
// - partner sleep raises lpi indication on rx
// - partner wake returns rx to normal idle
// - advertise eee capability to autonegotiation
// - autonegotiate at reset, command, link loss
// - eee only when both ends advertise it
// - tx and rx lpi run independently
// - wake status bits energy, link, pattern
// - software routes energy and link wake to irq or pme; pattern always raises pme
// - energy event after configured continuous presence
// - pattern scan only when mask bit set
// - sync run then sixteen address copies
// - broadcast frames with own address copies accepted
// - frames without pattern cause no action
// - pattern detection asserts power event output
// - lpi holds mac off; release after wake
// - pme status flag clears on read
module eee_lpi_wake
   import eee_pkg::*;
#(
   parameter int QUIET_CYCLES = QUIET_CYC
) (
   // clock and reset
   input  wire logic          sys_clk,
   input  wire logic          reset_n,
   // apb slave
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [7:0]    paddr,
   input  wire logic [31:0]   pwdata,
   output logic [31:0]        prdata,
   output logic               pready,
   output logic               pslverr,
   // transmit mii side
   input  wire logic          txLpiReq,
   input  wire logic          txFrameActive,
   output eee_tx_state_t      txLineState,
   output logic               macTxHold,
   // receive line side
   input  wire logic          rxSleepDet,
   input  wire logic          rxWakeDet,
   output logic               rxLpiInd,
   // autonegotiation
   input  wire logic          anDone,
   input  wire logic          partnerEeeAdv,
   output logic               eeeAdvertise,
   output logic               anStart,
   // wake sources
   input  wire logic          energyDet,
   input  wire logic          linkUp,
   input  wire logic          rxValid,
   input  wire logic          rxStart,
   input  wire logic [7:0]    rxData,
   // host notification
   output logic               host_irq_n,
   output logic               power_event_out
);
   // pin synchronisers
   logic [5:0]    pinMeta;
   logic [5:0]    pinSync;
   // registers
   logic          ctrlPme;
   logic          anCmd;
   logic          anPending;
   logic [2:0]    wakeMask;
   logic [15:0]   energyTime;
   logic [47:0]   nodeAddr;
   logic [2:0]    wakeStatus;
   logic          eeeActive;
   logic          linkPrev;
   logic [15:0]   energyCnt;
   logic          energyFired;
   // transmit sequencer, read value, next wake status and receive bus
   eee_tx_state_t txState;
   eee_tx_state_t next_txState;
   logic [CNT_W-1:0] txCnt;
   logic [CNT_W-1:0] next_txCnt;
   logic [31:0]   rdValue;
   logic [2:0]    next_wakeStatus;
   eee_rx_if      rxBus ();

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pinMeta <= 6'h00;
         pinSync <= 6'h00;
      end else begin
         pinMeta <= {energyDet, linkUp, rxSleepDet, rxWakeDet, anDone, partnerEeeAdv};
         pinSync <= pinMeta;
      end
   end
   wire logic energySync  = pinSync[5];
   wire logic linkSync    = pinSync[4];
   wire logic rxSleepSync = pinSync[3];
   wire logic rxWakeSync  = pinSync[2];
   wire logic anDoneSync  = pinSync[1];
   wire logic partnerSync = pinSync[0];

   // apb decode; one wait state, effects land on the edge that sees pready
   wire logic apbAccess = psel & penable;
   wire logic apbDone   = apbAccess & pready;
   wire logic apbWr     = apbDone & pwrite;
   wire logic apbRd     = apbDone & ~pwrite;
   wire logic selCtrl   = paddr == A_CTRL;
   wire logic selStatus = paddr == A_STATUS;
   wire logic selWakeSt = paddr == A_WAKE_ST;
   wire logic selWakeMk = paddr == A_WAKE_MK;
   wire logic selEnergy = paddr == A_ENERGY;
   wire logic selAddrLo = paddr == A_ADDR_LO;
   wire logic selAddrHi = paddr == A_ADDR_HI;
   wire logic selInt    = paddr == A_INT_ST;
   wire logic mapped    = selCtrl | selStatus | selWakeSt | selWakeMk |
                          selEnergy | selAddrLo | selAddrHi | selInt;

   assign rdValue =
      ({32{selCtrl}}   & {29'h0, ctrlPme, 1'b0, eeeAdvertise}) |
      ({32{selStatus}} & {24'h0, anDoneSync, linkSync, rxLpiInd, macTxHold,
                          eeeActive, txState}) |
      ({32{selWakeSt}} & {29'h0, wakeStatus}) |
      ({32{selWakeMk}} & {29'h0, wakeMask}) |
      ({32{selEnergy}} & {16'h0, energyTime}) |
      ({32{selAddrLo}} & nodeAddr[31:0]) |
      ({32{selAddrHi}} & {16'h0, nodeAddr[47:32]}) |
      ({32{selInt}}    & {27'h0, power_event_out, 4'h0});

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= apbAccess & ~pready;
         pslverr <= apbAccess & ~pready & ~mapped;
         prdata  <= (apbAccess && !pready && !pwrite) ? rdValue : 32'h0000_0000;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         eeeAdvertise <= 1'b0;
         ctrlPme      <= 1'b0;
         anCmd        <= 1'b0;
         wakeMask     <= WAKE_MK_RST;
         energyTime   <= ENERGY_RST;
         nodeAddr     <= ADDR_RST;
      end else begin
         anCmd <= apbWr & selCtrl & pwdata[CTRL_AN];
         if (apbWr && selCtrl) begin
            eeeAdvertise <= pwdata[CTRL_ADV];
            ctrlPme      <= pwdata[CTRL_PME];
         end
         if (apbWr && selWakeMk) wakeMask <= pwdata[2:0];
         if (apbWr && selEnergy) energyTime <= pwdata[15:0];
         if (apbWr && selAddrLo) nodeAddr[31:0] <= pwdata;
         if (apbWr && selAddrHi) nodeAddr[47:32] <= pwdata[15:0];
      end
   end

   // negotiation: restart after reset, on command and when link drops
   wire logic linkFell = linkPrev & ~linkSync;
   wire logic linkRose = ~linkPrev & linkSync;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         anPending <= 1'b1;
         anStart   <= 1'b0;
         linkPrev  <= 1'b0;
         eeeActive <= 1'b0;
      end else begin
         anPending <= 1'b0;
         anStart   <= anPending | anCmd | linkFell;
         linkPrev  <= linkSync;
         eeeActive <= anDoneSync & eeeAdvertise & partnerSync;
      end
   end

   // transmit lpi sequencer; only leaves normal between frames
   wire logic lpiWanted = txLpiReq & eeeActive;
   wire logic cntDone   = txCnt == '0;

   always_comb begin
      next_txState = txState;
      next_txCnt   = cntDone ? txCnt : txCnt - 1'b1;
      case (txState)
         TX_NORMAL: begin
            if (lpiWanted && !txFrameActive) begin
               next_txState = TX_SLEEP;
               next_txCnt   = CNT_W'(SLEEP_CYC - 1);
            end
         end
         TX_SLEEP: begin
            if (cntDone) begin
               next_txState = TX_QUIET;
               next_txCnt   = CNT_W'(QUIET_CYCLES - 1);
            end
         end
         TX_QUIET: begin
            if (!lpiWanted) begin
               next_txState = TX_WAKE;
               next_txCnt   = CNT_W'(WAKE_CYC - 1);
            end else if (cntDone) begin
               next_txState = TX_REFRESH;
               next_txCnt   = CNT_W'(REFRESH_CYC - 1);
            end
         end
         TX_REFRESH: begin
            if (!lpiWanted) begin
               next_txState = TX_WAKE;
               next_txCnt   = CNT_W'(WAKE_CYC - 1);
            end else if (cntDone) begin
               next_txState = TX_QUIET;
               next_txCnt   = CNT_W'(QUIET_CYCLES - 1);
            end
         end
         TX_WAKE: begin
            if (cntDone) next_txState = TX_NORMAL;
         end
         default: begin
            next_txState = TX_NORMAL;
            next_txCnt   = '0;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         txState     <= TX_NORMAL;
         txLineState <= TX_NORMAL;
         txCnt       <= '0;
         macTxHold   <= 1'b0;
      end else begin
         txState     <= next_txState;
         txLineState <= next_txState;
         txCnt       <= next_txCnt;
         // mac stays held through wake so the partner is ready first
         macTxHold   <= (next_txState != TX_NORMAL) | lpiWanted;
      end
   end

   // receive lpi indication, independent of the transmit sequencer
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rxLpiInd <= 1'b0;
      end else if (!eeeActive || rxWakeSync) begin
         rxLpiInd <= 1'b0;
      end else if (rxSleepSync) begin
         rxLpiInd <= 1'b1;
      end
   end

   // energy must stay present without a gap for more than energyTime cycles
   wire logic energyEvent = energySync & ~energyFired & (energyCnt == energyTime);

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         energyCnt   <= 16'h0000;
         energyFired <= 1'b0;
      end else if (!energySync) begin
         energyCnt   <= 16'h0000;
         energyFired <= 1'b0;
      end else begin
         energyCnt   <= (energyCnt == energyTime) ? energyCnt : energyCnt + 16'h0001;
         energyFired <= energyFired | energyEvent;
      end
   end

   // wake pattern matcher sees every received byte while enabled
   assign rxBus.scanEn     = wakeMask[WK_PATTERN];
   assign rxBus.nodeAddr   = nodeAddr;
   assign rxBus.byteValid  = rxValid;
   assign rxBus.frameStart = rxStart;
   assign rxBus.byteData   = rxData;

   eee_wake_match u_match (
      .sys_clk (sys_clk),
      .reset_n (reset_n),
      .bus     (rxBus)
   );

   // sticky flags: a new event in the clearing cycle survives the clear
   wire logic [2:0] wakeEvents = {rxBus.found, linkRose, energyEvent};
   wire logic [2:0] wakeClear  = (apbWr && selWakeSt) ? pwdata[2:0] : 3'h0;
   assign next_wakeStatus = (wakeStatus & ~wakeClear) | wakeEvents;
   wire logic wakeReport = |(next_wakeStatus & wakeMask);
   wire logic pmeSet     = (ctrlPme & |(wakeEvents & wakeMask)) | rxBus.found;
   wire logic pmeRdClr   = apbRd & selInt;

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         wakeStatus      <= 3'h0;
         host_irq_n      <= 1'b1;
         power_event_out <= 1'b0;
      end else begin
         wakeStatus      <= next_wakeStatus;
         host_irq_n      <= ~(wakeReport & ~ctrlPme);
         power_event_out <= pmeSet | (power_event_out & ~pmeRdClr);
      end
   end

   default clocking dcb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   sequence s_enter_sleep;
      txState == TX_NORMAL ##1 txState == TX_SLEEP;
   endsequence
   sequence s_enter_wake;
      txState != TX_WAKE ##1 txState == TX_WAKE;
   endsequence

   a_sleep_length: assert property (s_enter_sleep |-> txState == TX_SLEEP [*8])
      else $error("sleep signal shorter than allowed");
   a_quiet_source: assert property ($rose(txState == TX_QUIET) |->
      $past(txState) == TX_SLEEP || $past(txState) == TX_REFRESH)
      else $error("quiet entered from wrong phase");
   a_wake_length: assert property (s_enter_wake |-> txState == TX_WAKE [*8])
      else $error("wake signal cut short");
   a_normal_after_wake: assert property ($rose(txState == TX_NORMAL) |->
      $past(txState) == TX_WAKE)
      else $error("normal state reached without wake");
   a_frame_safe: assert property (txState == TX_NORMAL && txFrameActive |=>
      txState == TX_NORMAL)
      else $error("lpi entered during a frame");
   a_eee_gate: assert property (txState == TX_NORMAL && !eeeActive |=>
      txState == TX_NORMAL ##1 !macTxHold || txLpiReq)
      else $error("lpi used while eee not agreed");
   a_mac_hold: assert property (txState != TX_NORMAL |-> macTxHold)
      else $error("mac released during lpi");
   a_rx_assert: assert property (eeeActive && rxSleepSync && !rxWakeSync |=>
      rxLpiInd)
      else $error("partner sleep not indicated on rx");
   a_rx_wake: assert property (rxWakeSync |=> !rxLpiInd ##1 !rxLpiInd || rxSleepSync)
      else $error("partner wake did not end rx lpi");
   a_an_relink: assert property (linkFell |=> anStart)
      else $error("link loss did not restart negotiation");
   a_pme_clear: assert property (pmeRdClr && !pmeSet |=> !power_event_out)
      else $error("power event flag survived its read");
   a_energy_long: assert property ($rose(wakeStatus[WK_ENERGY]) |->
      $past(energyCnt) == energyTime && $past(energySync))
      else $error("energy event before configured time");
endmodule : eee_lpi_wake

/* rtl/eee_pkg.sv */
// shared constants and types for the lpi sequencer and wake detector
package eee_pkg;
   // clock rate and documented line timings
   localparam int CLK_HZ     = 10_000_000;
   localparam int SLEEP_US   = 200;
   localparam int REFRESH_US = 200;
   localparam int QUIET_MS   = 20;
   localparam int WAKE_US    = 20;
   // least times, so whole cycles are rounded up
   localparam int SLEEP_CYC   = (SLEEP_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int REFRESH_CYC = (REFRESH_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int WAKE_CYC    = (WAKE_US * CLK_HZ + 999_999) / 1_000_000;
   localparam int QUIET_CYC   = (QUIET_MS * CLK_HZ + 999) / 1000;
   localparam int CNT_W       = 18;

   // register byte offsets
   localparam logic [7:0] A_CTRL    = 8'h00;
   localparam logic [7:0] A_STATUS  = 8'h04;
   localparam logic [7:0] A_WAKE_ST = 8'h08;
   localparam logic [7:0] A_WAKE_MK = 8'h0C;
   localparam logic [7:0] A_ENERGY  = 8'h10;
   localparam logic [7:0] A_ADDR_LO = 8'h14;
   localparam logic [7:0] A_ADDR_HI = 8'h18;
   localparam logic [7:0] A_INT_ST  = 8'h1C;

   // field positions
   localparam int CTRL_ADV   = 0;
   localparam int CTRL_AN    = 1;
   localparam int CTRL_PME   = 2;
   localparam int WK_ENERGY  = 0;
   localparam int WK_LINK    = 1;
   localparam int WK_PATTERN = 2;
   localparam int INT_PME    = 4;

   // reset values
   localparam logic [2:0]  WAKE_MK_RST = 3'h0;
   localparam logic [15:0] ENERGY_RST  = 16'h03E8;
   localparam logic [47:0] ADDR_RST    = 48'h0000_0000_0000;

   // wake pattern shape
   localparam int         SYNC_LEN   = 6;
   localparam int         ADDR_BYTES = 6;
   localparam int         COPIES     = 16;
   localparam logic [7:0] SYNC_BYTE  = 8'hFF;

   typedef enum logic [2:0] {
      TX_NORMAL  = 3'b000,
      TX_SLEEP   = 3'b001,
      TX_QUIET   = 3'b010,
      TX_REFRESH = 3'b011,
      TX_WAKE    = 3'b100
   } eee_tx_state_t;
endpackage : eee_pkg

/* rtl/eee_rx_if.sv */
`timescale 1ns/1ps
// receive byte stream and match result between top and wake matcher
interface eee_rx_if;
   logic        scanEn;
   logic [47:0] nodeAddr;
   logic        byteValid;
   logic        frameStart;
   logic [7:0]  byteData;
   logic        found;
   modport src (output scanEn, nodeAddr, byteValid, frameStart, byteData,
                input found);
   modport dst (input scanEn, nodeAddr, byteValid, frameStart, byteData,
                output found);
endinterface : eee_rx_if

/* rtl/eee_wake_match.sv */
`timescale 1ns/1ps
// scanner for a sync run followed by sixteen copies of the node address
module eee_wake_match
   import eee_pkg::*;
(
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic reset_n,
   // byte stream in, match pulse out
   eee_rx_if.dst     bus
);
   logic [2:0]  ffRun;
   logic        inCopy;
   logic [2:0]  byteIdx;
   logic [3:0]  copyCnt;
   logic [2:0]  next_ffRun;
   logic        next_inCopy;
   logic [2:0]  next_byteIdx;
   logic [3:0]  next_copyCnt;
   logic        next_found;
   logic [47:0] shifted;

   // first address byte on the wire is the most significant one
   assign shifted = bus.nodeAddr << {byteIdx, 3'b000};
   wire logic [7:0] expByte  = shifted[47:40];
   wire logic       take     = bus.byteValid & bus.scanEn;
   wire logic       isSync   = bus.byteData == SYNC_BYTE;
   wire logic       hit      = bus.byteData == expByte;
   wire logic       lastByte = byteIdx == 3'(ADDR_BYTES - 1);
   wire logic       lastCopy = copyCnt == 4'(COPIES - 1);
   wire logic       synced   = ffRun == 3'(SYNC_LEN);
   wire logic       fresh    = bus.frameStart | ~bus.scanEn;

   always_comb begin
      next_ffRun   = fresh ? 3'h0 : ffRun;
      next_inCopy  = fresh ? 1'b0 : inCopy;
      next_byteIdx = fresh ? 3'h0 : byteIdx;
      next_copyCnt = fresh ? 4'h0 : copyCnt;
      next_found   = 1'b0;
      if (take) begin
         if (next_inCopy) begin
            if (hit && lastByte) begin
               next_byteIdx = 3'h0;
               next_copyCnt = copyCnt + 4'h1;
               if (lastCopy) begin
                  next_found  = 1'b1;
                  next_inCopy = 1'b0;
                  next_ffRun  = 3'h0;
               end
            end else if (hit) begin
               next_byteIdx = byteIdx + 3'h1;
            end else begin
               // a gap between copies breaks the match; an ff may open a new run
               next_inCopy = 1'b0;
               next_ffRun  = isSync ? 3'h1 : 3'h0;
            end
         end else if (next_ffRun == 3'(SYNC_LEN) && !isSync && hit) begin
            next_inCopy  = 1'b1;
            next_byteIdx = 3'h1;
            next_copyCnt = 4'h0;
         end else if (isSync) begin
            next_ffRun = (next_ffRun == 3'(SYNC_LEN)) ? next_ffRun : next_ffRun + 3'h1;
         end else begin
            next_ffRun = 3'h0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         ffRun     <= 3'h0;
         inCopy    <= 1'b0;
         byteIdx   <= 3'h0;
         copyCnt   <= 4'h0;
         bus.found <= 1'b0;
      end else begin
         ffRun     <= next_ffRun;
         inCopy    <= next_inCopy;
         byteIdx   <= next_byteIdx;
         copyCnt   <= next_copyCnt;
         bus.found <= next_found;
      end
   end

   a_found_enabled: assert property (@(posedge sys_clk) disable iff (!reset_n)
      bus.found |-> $past(bus.scanEn) && $past(inCopy) && $past(lastCopy))
      else $error("pattern reported without scan enabled or full run");
   a_copy_needs_sync: assert property (@(posedge sys_clk) disable iff (!reset_n)
      $rose(inCopy) |-> $past(synced))
      else $error("address copies started without a full sync run");
endmodule : eee_wake_match

/* testbench/eee_link_partner.sv */
// cable link partner model: line detect levels, negotiation pins, received bytes
`timescale 1ns/1ps
module eee_link_partner
   import eee_pkg::*;
(
   // clock
   input  wire logic  sys_clk,
   // line and negotiation levels
   output logic       rxSleepDet,
   output logic       rxWakeDet,
   output logic       anDone,
   output logic       partnerEeeAdv,
   output logic       energyDet,
   output logic       linkUp,
   // received byte stream
   output logic       rxValid,
   output logic       rxStart,
   output logic [7:0] rxData
);
   initial begin
      {rxSleepDet, rxWakeDet, rxValid, rxStart} = 4'h0;
      {anDone, partnerEeeAdv, energyDet, linkUp} = 4'h0;
      rxData = 8'hA5;
   end
   task automatic set(input logic [3:0] v);
      @(posedge sys_clk);
      anDone        <= v[3];
      partnerEeeAdv <= v[2];
      energyDet     <= v[1];
      linkUp        <= v[0];
   endtask : set
   task automatic sleep;
      @(posedge sys_clk);
      rxSleepDet <= 1'b1;
   endtask : sleep
   // wake is held for the whole wake time, as a real partner would
   task automatic wake;
      @(posedge sys_clk);
      rxSleepDet <= 1'b0;
      rxWakeDet <= 1'b1;
      repeat (WAKE_CYC) @(posedge sys_clk);
      rxWakeDet <= 1'b0;
   endtask : wake
   task automatic put(input logic [7:0] b, input logic first);
      @(posedge sys_clk);
      rxValid <= 1'b1;
      rxStart <= first;
      rxData <= b;
   endtask : put
   // addressed frame with header, sync run, n copies and check bytes
   task automatic frame(input logic [47:0] a, input int n, input logic bc);
      for (int i = 0; i < 14; i++) put(i < 6 ? (bc ? 8'hFF : a[47-8*i -: 8]) : 8'h02, i == 0);
      repeat (SYNC_LEN) put(SYNC_BYTE, 1'b0);
      for (int i = 0; i < 6 * n; i++) put(a[47-8*(i%6) -: 8], 1'b0);
      repeat (4) put(8'h00, 1'b0);
      @(posedge sys_clk);
      // released line shows the inverse, never a stale byte
      rxValid <= 1'b0;
      rxData <= ~rxData;
   endtask : frame
endmodule : eee_link_partner

/* testbench/testbench.sv */
// self-checking bench for the lpi sequencer and wake detector
`timescale 1ns/1ps
module testbench
   import eee_pkg::*;
;
   localparam logic [47:0] NODE = 48'h0A1B2C3D4E5F;
   logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, rxData;
   logic [31:0] pwdata, prdata;
   logic txLpiReq, txFrameActive, macTxHold, rxSleepDet, rxWakeDet, rxLpiInd;
   logic anDone, partnerEeeAdv, eeeAdvertise, anStart, energyDet, linkUp;
   logic rxValid, rxStart, host_irq_n, power_event_out;
   eee_tx_state_t txLineState;
   int errors = 0, n_compared = 0, anCnt = 0;

   eee_lpi_wake #(.QUIET_CYCLES(40)) DUT (.sys_clk(sys_clk), .reset_n(reset_n),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .txLpiReq(txLpiReq),
      .txFrameActive(txFrameActive), .txLineState(txLineState), .macTxHold(macTxHold),
      .rxSleepDet(rxSleepDet), .rxWakeDet(rxWakeDet), .rxLpiInd(rxLpiInd),
      .anDone(anDone), .partnerEeeAdv(partnerEeeAdv), .eeeAdvertise(eeeAdvertise),
      .anStart(anStart), .energyDet(energyDet), .linkUp(linkUp), .rxValid(rxValid),
      .rxStart(rxStart), .rxData(rxData), .host_irq_n(host_irq_n),
      .power_event_out(power_event_out));
   eee_link_partner lp (.sys_clk(sys_clk), .rxSleepDet(rxSleepDet), .rxWakeDet(rxWakeDet),
      .anDone(anDone), .partnerEeeAdv(partnerEeeAdv), .energyDet(energyDet),
      .linkUp(linkUp), .rxValid(rxValid), .rxStart(rxStart), .rxData(rxData));

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) if (anStart === 1'b1) anCnt++;

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic se);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      q = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic se = 1'b0);
      logic [31:0] q;
      logic s;
      apb(1'b0, a, 32'h0, q, s);
      chk("read data", e, q);
      chk("slave error", {31'h0, se}, {31'h0, s});
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic s;
      apb(1'b1, a, d, q, s);
   endtask : wr
   task automatic dur(input eee_tx_state_t s, input int n);
      int c;
      c = 0;
      do begin
         @(negedge sys_clk);
         c++;
      end while (txLineState === s && c <= n);
      chk("phase length", 32'(n), 32'(c));
   endtask : dur
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   initial begin
      #2_000_000;
      errors++;
      $display("[ERR] watchdog expected done seen hang");
      print_verdict();
   end

   initial begin
      {psel, penable, pwrite, txLpiReq, txFrameActive} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      reset_n = 1'b0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      rd(A_CTRL, 32'h0);
      rd(A_WAKE_MK, {29'h0, WAKE_MK_RST});
      rd(A_ENERGY, {16'h0, ENERGY_RST});
      rd(8'h40, 32'h0, 1'b1);
      chk("anStart count", 32'h1, anCnt);
      // request held while nothing negotiated, then while a frame runs
      txLpiReq <= 1'b1;
      txFrameActive <= 1'b1;
      repeat (20) @(posedge sys_clk);
      chk("tx phase", TX_NORMAL, txLineState);
      wr(A_CTRL, 32'h3);
      // the command pulse is counted one edge after the access ends
      repeat (2) @(negedge sys_clk);
      chk("anStart count", 32'h2, anCnt);
      chk("advertise", 32'h1, eeeAdvertise);
      lp.set(4'b1100);
      repeat (10) @(posedge sys_clk);
      chk("tx phase", TX_NORMAL, txLineState);
      txFrameActive <= 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("tx phase", TX_SLEEP, txLineState);
      chk("mac hold", 32'h1, macTxHold);
      dur(TX_SLEEP, SLEEP_CYC);
      dur(TX_QUIET, 40);
      dur(TX_REFRESH, REFRESH_CYC);
      @(posedge sys_clk);
      txLpiReq <= 1'b0;
      repeat (2) @(negedge sys_clk);
      chk("tx phase", TX_WAKE, txLineState);
      dur(TX_WAKE, WAKE_CYC);
      chk("mac hold", 32'h0, macTxHold);
      lp.sleep();
      repeat (4) @(negedge sys_clk);
      chk("rx lpi", 32'h1, rxLpiInd);
      chk("tx phase", TX_NORMAL, txLineState);
      lp.wake();
      repeat (4) @(negedge sys_clk);
      chk("rx lpi", 32'h0, rxLpiInd);
      // energy for exactly the configured time, then longer than it
      wr(A_ENERGY, 32'h5);
      wr(A_WAKE_MK, 32'h3);
      wr(A_CTRL, 32'h1);
      lp.set(4'b1110);
      repeat (4) @(posedge sys_clk);
      lp.set(4'b1100);
      repeat (4) @(posedge sys_clk);
      rd(A_WAKE_ST, 32'h0);
      lp.set(4'b1110);
      repeat (20) @(posedge sys_clk);
      rd(A_WAKE_ST, 32'h1);
      chk("irq", 32'h0, host_irq_n);
      lp.set(4'b1101);
      repeat (6) @(posedge sys_clk);
      rd(A_WAKE_ST, 32'h3);
      wr(A_WAKE_ST, 32'h7);
      rd(A_WAKE_ST, 32'h0);
      chk("irq", 32'h1, host_irq_n);
      // pattern frames: masked off, one copy short, then broadcast match
      wr(A_ADDR_LO, NODE[31:0]);
      wr(A_ADDR_HI, {16'h0, NODE[47:32]});
      wr(A_WAKE_MK, 32'h0);
      lp.frame(NODE, 16, 1'b0);
      rd(A_WAKE_ST, 32'h0);
      wr(A_WAKE_MK, 32'h4);
      lp.frame(NODE, 15, 1'b0);
      rd(A_WAKE_ST, 32'h0);
      chk("power event", 32'h0, power_event_out);
      lp.frame(NODE, 16, 1'b1);
      rd(A_WAKE_ST, 32'h4);
      chk("power event", 32'h1, power_event_out);
      rd(A_INT_ST, 32'h10);
      rd(A_INT_ST, 32'h0);
      // link loss restarts negotiation; link-up routed to the power event pin
      wr(A_CTRL, 32'h5);
      wr(A_WAKE_MK, 32'h2);
      lp.set(4'b1100);
      repeat (6) @(negedge sys_clk);
      chk("anStart count", 32'h3, anCnt);
      lp.set(4'b1101);
      repeat (6) @(negedge sys_clk);
      chk("power event", 32'h1, power_event_out);
      chk("irq", 32'h1, host_irq_n);
      print_verdict();
   end
endmodule : testbench
